// [output_terminal_function_select.sv]
// Purpose: routes internal status events onto four output terminals
// Assumes: status inputs arrive from pins and are synchronised here
// Notes:   codes with no source listed here drive the terminal inactive

module output_terminal_function_select
#(
    parameter int HOLD_CYC = outsel_pkg::PULSE_HOLD_CYC
)
(
    input  wire logic        CLOCK,
    input  wire logic        RESET,
    input  wire logic [11:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic        HSEL,
    input  wire logic        HREADY,
    input  wire logic [31:0] HWDATA,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        STAGE_DONE,
    input  wire logic        CYCLE_DONE,
    input  wire logic        DC_BUS_OK,
    input  wire logic        INDEX_PULSE,
    input  wire logic        SUPERPOSE_ACTIVE,
    input  wire logic        SAFE_TORQUE_OFF_FAULT,
    input  wire logic        POSITION_DONE,
    input  wire logic        ZEROING_DONE,
    input  wire logic        DIVISION_DONE,
    input  wire logic        SPEED_LIMITED,
    input  wire logic        MODE_SWITCH_DONE,
    input  wire logic        FREQ_ABOVE_REACH,
    input  wire logic [6:0]  CARD_OUTPUTS,
    input  wire logic [2:0]  OVERHEAT_PREALARM,
    input  wire logic        STOPPED_OR_ZERO,
    input  wire logic        MATERIAL_BREAK,
    input  wire logic [2:0]  ROLL_REACHED,
    input  wire logic        FIRE_MODE,
    output logic             OPEN_COLLECTOR_OUT_ONE,
    output logic             FAST_PULSE_OUT,
    output logic             RELAY_OUT_ONE,
    output logic             RELAY_OUT_TWO
);

    localparam int NSRC = 28;
    localparam int CW   = $clog2(HOLD_CYC + 1);

    //--------------------------------------------------------------------
    // state
    //--------------------------------------------------------------------
    typedef struct packed {
        logic [NSRC-1:0]                          s1;
        logic [NSRC-1:0]                          s2;
        logic [outsel_pkg::NUM_TERMS-1:0][5:0]    sel;
        logic [3:0]                               virt;
        logic                                     idx_prev;
        logic [CW-1:0]                            hold;
        logic                                     ph_wr;
        logic                                     ph_rd;
        logic [11:0]                              ph_addr;
        logic [31:0]                              rdata;
        logic [outsel_pkg::NUM_TERMS-1:0]         outs;
    } state_t;

    state_t state_q;
    state_t state_d;

    logic [NSRC-1:0]                        raw_src;
    logic [NSRC-1:0]                        sync_src;
    logic                                   index_out;
    logic [outsel_pkg::NUM_TERMS-1:0]       term_val;

    // bundle all asynchronous sources for one synchroniser bank
    assign raw_src = {FIRE_MODE, ROLL_REACHED, MATERIAL_BREAK,
                      STOPPED_OR_ZERO, OVERHEAT_PREALARM, CARD_OUTPUTS,
                      FREQ_ABOVE_REACH, MODE_SWITCH_DONE, SPEED_LIMITED,
                      DIVISION_DONE, ZEROING_DONE, POSITION_DONE,
                      SAFE_TORQUE_OFF_FAULT, SUPERPOSE_ACTIVE, INDEX_PULSE,
                      DC_BUS_OK, CYCLE_DONE, STAGE_DONE};
    assign sync_src = state_q.s2;

    // index stretch output is high while the hold counter runs
    assign index_out = (state_q.hold != '0);

    //--------------------------------------------------------------------
    // source selection
    //--------------------------------------------------------------------
    // one decoder function called once per terminal, so terminals with equal codes see one source
    function automatic logic pick(input logic [5:0]      code,
                                  input logic [NSRC-1:0] s,
                                  input logic [3:0]      v,
                                  input logic            idx);
        logic r;
        r = 1'b0;
        case (code)
            outsel_pkg::C_NONE:        r = 1'b0;
            outsel_pkg::C_STAGE_DONE:  r = s[0];
            outsel_pkg::C_CYCLE_DONE:  r = s[1];
            outsel_pkg::C_V_MODBUS:    r = v[outsel_pkg::VB_MODBUS];
            outsel_pkg::C_V_PBUS:      r = v[outsel_pkg::VB_PBUS_CAN];
            outsel_pkg::C_V_ETH:       r = v[outsel_pkg::VB_ETH];
            outsel_pkg::C_DC_BUS:      r = s[2];
            outsel_pkg::C_INDEX:       r = idx;
            outsel_pkg::C_SUPERPOSE:   r = s[4];
            outsel_pkg::C_SAFE_TORQUE: r = s[5];
            outsel_pkg::C_POS_DONE:    r = s[6];
            outsel_pkg::C_ZERO_DONE:   r = s[7];
            outsel_pkg::C_DIV_DONE:    r = s[8];
            outsel_pkg::C_SPD_LIMIT:   r = s[9];
            outsel_pkg::C_V_IND_ETH:   r = v[outsel_pkg::VB_IND_ETH];
            outsel_pkg::C_MODE_SWITCH: r = s[10];
            outsel_pkg::C_FREQ_ABOVE:  r = s[11];
            outsel_pkg::C_STOPPED:     r = s[22];
            outsel_pkg::C_BREAK:       r = s[23];
            outsel_pkg::C_FIRE:        r = s[NSRC-1];
            default:
            begin
                if (code >= outsel_pkg::C_CARD_FIRST &&
                    code <= outsel_pkg::C_CARD_LAST)
                    r = s[12 + 4'(code - outsel_pkg::C_CARD_FIRST)];
                else if (code >= outsel_pkg::C_OH_FIRST &&
                         code <= outsel_pkg::C_OH_LAST)
                    r = s[19 + 2'(code - outsel_pkg::C_OH_FIRST)];
                else if (code >= outsel_pkg::C_ROLL_FIRST &&
                         code <= outsel_pkg::C_ROLL_LAST)
                    r = s[24 + 2'(code - outsel_pkg::C_ROLL_FIRST)];
                else
                    r = 1'b0;
            end
        endcase
        return r;
    endfunction : pick

    generate
        for (genvar t = 0; t < outsel_pkg::NUM_TERMS; t++)
        begin : g_term
            assign term_val[t] = pick(state_q.sel[t], sync_src,
                                      state_q.virt, index_out);
        end
    endgenerate

    //--------------------------------------------------------------------
    // next state
    //--------------------------------------------------------------------
    // reads return whole-word state; writes land in the data phase
    always_comb
    begin
        logic take;
        take = 1'b0;
        state_d = state_q;
        state_d.s1 = raw_src;
        state_d.s2 = state_q.s1;
        state_d.idx_prev = sync_src[3];
        state_d.outs = term_val;
        // 10 ms hold, restarts on every new index edge
        if (sync_src[3] && !state_q.idx_prev)
            state_d.hold = CW'(HOLD_CYC);
        else if (state_q.hold != '0)
            state_d.hold = state_q.hold - CW'(1);
        // data phase of a previous write
        if (state_q.ph_wr)
        begin
            case (state_q.ph_addr)
                outsel_pkg::OFS_SEL_OC:   state_d.sel[0] = HWDATA[5:0];
                outsel_pkg::OFS_SEL_FAST: state_d.sel[1] = HWDATA[5:0];
                outsel_pkg::OFS_SEL_RLY1: state_d.sel[2] = HWDATA[5:0];
                outsel_pkg::OFS_SEL_RLY2: state_d.sel[3] = HWDATA[5:0];
                outsel_pkg::OFS_VIRT:     state_d.virt   = HWDATA[3:0];
                default:                  state_d.virt   = state_q.virt;
            endcase
        end
        // address phase
        take = HSEL && HREADY && HTRANS[1];
        state_d.ph_wr = take && HWRITE;
        state_d.ph_rd = take && !HWRITE;
        state_d.ph_addr = {HADDR[11:2], 2'b00};
        if (take && !HWRITE)
        begin
            case ({HADDR[11:2], 2'b00})
                outsel_pkg::OFS_SEL_OC:
                    state_d.rdata = {26'h0, state_q.sel[0]};
                outsel_pkg::OFS_SEL_FAST:
                    state_d.rdata = {26'h0, state_q.sel[1]};
                outsel_pkg::OFS_SEL_RLY1:
                    state_d.rdata = {26'h0, state_q.sel[2]};
                outsel_pkg::OFS_SEL_RLY2:
                    state_d.rdata = {26'h0, state_q.sel[3]};
                outsel_pkg::OFS_VIRT:
                    state_d.rdata = {28'h0, state_q.virt};
                outsel_pkg::OFS_STATE:
                    state_d.rdata = {27'h0, index_out, state_q.outs};
                default:
                    state_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    //--------------------------------------------------------------------
    // registers
    //--------------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            state_q          <= '0;
            state_q.sel[0]   <= outsel_pkg::RST_SEL_OC;
            state_q.sel[1]   <= outsel_pkg::RST_SEL_FAST;
            state_q.sel[2]   <= outsel_pkg::RST_SEL_RLY1;
            state_q.sel[3]   <= outsel_pkg::RST_SEL_RLY2;
            state_q.virt     <= outsel_pkg::RST_VIRT;
        end
        else
            state_q <= state_d;
    end

    // zero-wait slave, always OKAY
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign HRDATA    = state_q.rdata;
    assign OPEN_COLLECTOR_OUT_ONE = state_q.outs[0];
    assign FAST_PULSE_OUT         = state_q.outs[1];
    assign RELAY_OUT_ONE          = state_q.outs[2];
    assign RELAY_OUT_TWO          = state_q.outs[3];

    //--------------------------------------------------------------------
    // checks
    //--------------------------------------------------------------------
    a_zero_code_off: assert property (@(posedge CLOCK) disable iff (RESET)
        $past(state_q.sel[0]) == outsel_pkg::C_NONE |-> !OPEN_COLLECTOR_OUT_ONE)
        else $error("code zero drove terminal");
    a_reserved_off: assert property (@(posedge CLOCK) disable iff (RESET)
        $past(state_q.sel[3]) == 6'd35 |-> !RELAY_OUT_TWO)
        else $error("reserved code drove relay");
    a_index_hold: assert property (@(posedge CLOCK) disable iff (RESET)
        $rose(state_q.hold != '0) |-> (state_q.hold == CW'(HOLD_CYC)))
        else $error("index hold wrong length");
    a_index_ends: assert property (@(posedge CLOCK) disable iff (RESET)
        state_q.hold == CW'(1) && !(sync_src[3] && !state_q.idx_prev)
        |=> !index_out)
        else $error("index output not released");
    a_shared_code: assert property (@(posedge CLOCK) disable iff (RESET)
        state_q.sel[2] == state_q.sel[3] |-> term_val[2] == term_val[3])
        else $error("shared code differs");
    a_fire_path: assert property (@(posedge CLOCK) disable iff (RESET)
        state_q.sel[1] == outsel_pkg::C_FIRE |=>
        FAST_PULSE_OUT == $past(sync_src[NSRC-1]))
        else $error("fire mode not routed");
    a_modbus_bit: assert property (@(posedge CLOCK) disable iff (RESET)
        state_q.sel[0] == outsel_pkg::C_V_MODBUS |=>
        OPEN_COLLECTOR_OUT_ONE == $past(state_q.virt[0]))
        else $error("modbus bit not followed");
    a_stage_done: assert property (@(posedge CLOCK) disable iff (RESET)
        state_q.sel[2] == outsel_pkg::C_STAGE_DONE |=>
        RELAY_OUT_ONE == $past(sync_src[0]))
        else $error("stage done not routed");
    a_sel_write: assert property (@(posedge CLOCK) disable iff (RESET)
        state_q.ph_wr && state_q.ph_addr == outsel_pkg::OFS_SEL_RLY1 |=>
        state_q.sel[2] == $past(HWDATA[5:0]))
        else $error("selection write lost");
    // remaining source routes except the index stretch, one code family each on a rotating terminal
    a_cycle_done: assert property (@(posedge CLOCK) disable iff (RESET)
        state_q.sel[3] == outsel_pkg::C_CYCLE_DONE |=>
        RELAY_OUT_TWO == $past(sync_src[1]))
        else $error("cycle done not routed");
    a_pbus_bit: assert property (@(posedge CLOCK) disable iff (RESET)
        state_q.sel[1] == outsel_pkg::C_V_PBUS |=>
        FAST_PULSE_OUT == $past(state_q.virt[outsel_pkg::VB_PBUS_CAN]))
        else $error("fieldbus bit not followed");
    a_eth_bit: assert property (@(posedge CLOCK) disable iff (RESET)
        state_q.sel[2] == outsel_pkg::C_V_ETH |=>
        RELAY_OUT_ONE == $past(state_q.virt[outsel_pkg::VB_ETH]))
        else $error("ethernet bit not followed");
    a_dc_bus: assert property (@(posedge CLOCK) disable iff (RESET)
        state_q.sel[3] == outsel_pkg::C_DC_BUS |=>
        RELAY_OUT_TWO == $past(sync_src[2]))
        else $error("dc bus not routed");
    a_superpose: assert property (@(posedge CLOCK) disable iff (RESET)
        state_q.sel[0] == outsel_pkg::C_SUPERPOSE |=>
        OPEN_COLLECTOR_OUT_ONE == $past(sync_src[4]))
        else $error("superposition not routed");
    a_torque_off: assert property (@(posedge CLOCK) disable iff (RESET)
        state_q.sel[1] == outsel_pkg::C_SAFE_TORQUE |=>
        FAST_PULSE_OUT == $past(sync_src[5]))
        else $error("torque off fault not routed");
    a_pos_done: assert property (@(posedge CLOCK) disable iff (RESET)
        state_q.sel[2] == outsel_pkg::C_POS_DONE |=>
        RELAY_OUT_ONE == $past(sync_src[6]))
        else $error("positioning not routed");
    a_zero_done: assert property (@(posedge CLOCK) disable iff (RESET)
        state_q.sel[3] == outsel_pkg::C_ZERO_DONE |=>
        RELAY_OUT_TWO == $past(sync_src[7]))
        else $error("zeroing not routed");
    a_div_done: assert property (@(posedge CLOCK) disable iff (RESET)
        state_q.sel[0] == outsel_pkg::C_DIV_DONE |=>
        OPEN_COLLECTOR_OUT_ONE == $past(sync_src[8]))
        else $error("indexing not routed");
    a_spd_limit: assert property (@(posedge CLOCK) disable iff (RESET)
        state_q.sel[1] == outsel_pkg::C_SPD_LIMIT |=>
        FAST_PULSE_OUT == $past(sync_src[9]))
        else $error("speed limit not routed");
    a_ind_eth_bit: assert property (@(posedge CLOCK) disable iff (RESET)
        state_q.sel[2] == outsel_pkg::C_V_IND_ETH |=>
        RELAY_OUT_ONE == $past(state_q.virt[outsel_pkg::VB_IND_ETH]))
        else $error("industrial bit not followed");
    a_mode_switch: assert property (@(posedge CLOCK) disable iff (RESET)
        state_q.sel[3] == outsel_pkg::C_MODE_SWITCH |=>
        RELAY_OUT_TWO == $past(sync_src[10]))
        else $error("mode switch not routed");
    a_freq_above: assert property (@(posedge CLOCK) disable iff (RESET)
        state_q.sel[0] == outsel_pkg::C_FREQ_ABOVE |=>
        OPEN_COLLECTOR_OUT_ONE == $past(sync_src[11]))
        else $error("frequency reach not routed");
    a_card_pass: assert property (@(posedge CLOCK) disable iff (RESET)
        state_q.sel[1] == outsel_pkg::C_CARD_LAST |=>
        FAST_PULSE_OUT == $past(sync_src[18]))
        else $error("card bit not passed");
    a_heat_alarm: assert property (@(posedge CLOCK) disable iff (RESET)
        state_q.sel[2] == outsel_pkg::C_OH_LAST |=>
        RELAY_OUT_ONE == $past(sync_src[21]))
        else $error("heat pre-alarm not routed");
    a_stopped: assert property (@(posedge CLOCK) disable iff (RESET)
        state_q.sel[3] == outsel_pkg::C_STOPPED |=>
        RELAY_OUT_TWO == $past(sync_src[22]))
        else $error("stopped state not routed");
    a_break: assert property (@(posedge CLOCK) disable iff (RESET)
        state_q.sel[0] == outsel_pkg::C_BREAK |=>
        OPEN_COLLECTOR_OUT_ONE == $past(sync_src[23]))
        else $error("material break not routed");
    a_roll_reach: assert property (@(posedge CLOCK) disable iff (RESET)
        state_q.sel[1] == outsel_pkg::C_ROLL_FIRST |=>
        FAST_PULSE_OUT == $past(sync_src[24]))
        else $error("roll diameter not routed");

endmodule : output_terminal_function_select

// [outsel_load_model.sv]
// Purpose: field load model energised by the four output terminals
// Assumes: each load picks up one clock after its terminal changes
// Notes:   real relays bounce; this model settles in a single cycle
module outsel_load_model
(
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic [3:0] term,
    output logic      [3:0] load_on
);
    // loads drop out at once on reset, like coils losing supply
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            load_on <= 4'h0;
        else
            load_on <= term;
    end
endmodule : outsel_load_model

// [outsel_pkg.sv]
// Purpose: constants for the output terminal function selector
// Assumes: 25 MHz clock, 32-bit AHB-Lite register access
// Notes:   selection codes are six bits wide
package outsel_pkg;

    localparam int          CLOCK_HZ       = 25_000_000;
    localparam int          PULSE_HOLD_MS  = 10;
    localparam int          PULSE_HOLD_CYC = CLOCK_HZ / 1000 * PULSE_HOLD_MS;
    localparam int          NUM_TERMS      = 4;
    localparam int          SEL_W          = 6;

    // register byte offsets
    localparam logic [11:0] OFS_SEL_OC     = 12'h000;
    localparam logic [11:0] OFS_SEL_FAST   = 12'h004;
    localparam logic [11:0] OFS_SEL_RLY1   = 12'h008;
    localparam logic [11:0] OFS_SEL_RLY2   = 12'h00C;
    localparam logic [11:0] OFS_VIRT       = 12'h010;
    localparam logic [11:0] OFS_STATE      = 12'h014;

    // virtual bit field positions
    localparam int          VB_MODBUS      = 0;
    localparam int          VB_PBUS_CAN    = 1;
    localparam int          VB_ETH         = 2;
    localparam int          VB_IND_ETH     = 3;

    // reset selection codes per terminal
    localparam logic [5:0]  RST_SEL_OC     = 6'h00;
    localparam logic [5:0]  RST_SEL_FAST   = 6'h00;
    localparam logic [5:0]  RST_SEL_RLY1   = 6'h01;
    localparam logic [5:0]  RST_SEL_RLY2   = 6'h05;
    localparam logic [3:0]  RST_VIRT       = 4'h0;

    // source codes
    localparam logic [5:0]  C_NONE         = 6'd0;
    localparam logic [5:0]  C_STAGE_DONE   = 6'd16;
    localparam logic [5:0]  C_CYCLE_DONE   = 6'd17;
    localparam logic [5:0]  C_V_MODBUS     = 6'd23;
    localparam logic [5:0]  C_V_PBUS       = 6'd24;
    localparam logic [5:0]  C_V_ETH        = 6'd25;
    localparam logic [5:0]  C_DC_BUS       = 6'd26;
    localparam logic [5:0]  C_INDEX        = 6'd27;
    localparam logic [5:0]  C_SUPERPOSE    = 6'd28;
    localparam logic [5:0]  C_SAFE_TORQUE  = 6'd29;
    localparam logic [5:0]  C_POS_DONE     = 6'd30;
    localparam logic [5:0]  C_ZERO_DONE    = 6'd31;
    localparam logic [5:0]  C_DIV_DONE     = 6'd32;
    localparam logic [5:0]  C_SPD_LIMIT    = 6'd33;
    localparam logic [5:0]  C_V_IND_ETH    = 6'd34;
    localparam logic [5:0]  C_MODE_SWITCH  = 6'd36;
    localparam logic [5:0]  C_FREQ_ABOVE   = 6'd37;
    localparam logic [5:0]  C_CARD_FIRST   = 6'd41;
    localparam logic [5:0]  C_CARD_LAST    = 6'd47;
    localparam logic [5:0]  C_OH_FIRST     = 6'd48;
    localparam logic [5:0]  C_OH_LAST      = 6'd50;
    localparam logic [5:0]  C_STOPPED      = 6'd51;
    localparam logic [5:0]  C_BREAK        = 6'd52;
    localparam logic [5:0]  C_ROLL_FIRST   = 6'd53;
    localparam logic [5:0]  C_ROLL_LAST    = 6'd55;
    localparam logic [5:0]  C_FIRE         = 6'd56;

endpackage : outsel_pkg

// [tb_output_terminal_function_select.sv]
// Purpose: self-checking bench for the output terminal selector
// Assumes: one slave on the bus, hready fed back from hreadyout
// Notes:   a pulse hold of 20 cycles keeps the run short
module tb_output_terminal_function_select;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int HOLD = 20;

    logic        clock    = 1'b0;
    logic        reset    = 1'b1;
    logic [11:0] haddr    = 12'h000;
    logic [1:0]  htrans   = 2'b00;
    logic        hwrite   = 1'b0;
    logic        hsel     = 1'b0;
    logic [2:0]  hsize    = 3'h2;
    logic [31:0] hwdata   = 32'h0000_0000;
    logic [27:0] src      = 28'h000_0000;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire         hresp;
    wire  [3:0]  term;
    wire  [3:0]  load_on;
    int          n_errors = 0;
    int          compares = 0;

    // 25 MHz clock
    always #20 clock = ~clock;

    output_terminal_function_select #(.HOLD_CYC(HOLD)) DUT
    (
        .CLOCK(clock), .RESET(reset), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(hsize), .HSEL(hsel), .HREADY(hreadyout),
        .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hreadyout),
        .HRESP(hresp), .STAGE_DONE(src[0]), .CYCLE_DONE(src[1]),
        .DC_BUS_OK(src[2]), .INDEX_PULSE(src[3]),
        .SUPERPOSE_ACTIVE(src[4]), .SAFE_TORQUE_OFF_FAULT(src[5]),
        .POSITION_DONE(src[6]), .ZEROING_DONE(src[7]),
        .DIVISION_DONE(src[8]), .SPEED_LIMITED(src[9]),
        .MODE_SWITCH_DONE(src[10]), .FREQ_ABOVE_REACH(src[11]),
        .CARD_OUTPUTS(src[18:12]), .OVERHEAT_PREALARM(src[21:19]),
        .STOPPED_OR_ZERO(src[22]), .MATERIAL_BREAK(src[23]),
        .ROLL_REACHED(src[26:24]), .FIRE_MODE(src[27]),
        .OPEN_COLLECTOR_OUT_ONE(term[0]), .FAST_PULSE_OUT(term[1]),
        .RELAY_OUT_ONE(term[2]), .RELAY_OUT_TWO(term[3])
    );

    outsel_load_model load
    (
        .clock(clock), .reset(reset), .term(term), .load_on(load_on)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    task automatic check(input string w, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", w, exp, seen);
        end
    endtask : check

    // bounded wait for hready at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 100);
        if (hreadyout !== 1'b1)
        begin
            n_errors++;
            end_sim();
        end
    endtask : wait_ready

    // one single word transfer; entered just after a rising edge
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        haddr  <= a;
        hwrite <= w;
        hsel   <= 1'b1;
        htrans <= 2'b10;
        wait_ready();
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr

    task automatic rd_chk(input string w, input logic [11:0] a,
                          input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0000_0000, x);
        check(w, x, exp);
    endtask : rd_chk

    // status levels on the pins, virtual bits through the register
    task automatic drive(input logic [27:0] s, input logic [3:0] v);
        src <= s;
        wr(outsel_pkg::OFS_VIRT, {28'h000_0000, v});
    endtask : drive

    // source bit for a code; 100 and up is a virtual bit, -1 none
    function automatic int src_of(input int c);
        case (c) inside
            16, 17:  return c - 16;
            23:      return 100 + outsel_pkg::VB_MODBUS;
            24:      return 100 + outsel_pkg::VB_PBUS_CAN;
            25:      return 100 + outsel_pkg::VB_ETH;
            [26:33]: return c - 24;
            34:      return 100 + outsel_pkg::VB_IND_ETH;
            36, 37:  return c - 26;
            [41:56]: return c - 29;
            default: return -1;
        endcase
    endfunction : src_of

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        int          k;
        logic [27:0] s;
        logic [3:0]  v;
        repeat (3) @(posedge clock);
        check("outs in reset", 32'(term), 32'h0000_0000);
        @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        rd_chk("sel oc rst", outsel_pkg::OFS_SEL_OC, 32'd0);
        rd_chk("sel fast rst", outsel_pkg::OFS_SEL_FAST, 32'd0);
        rd_chk("sel rly1 rst", outsel_pkg::OFS_SEL_RLY1, 32'd1);
        wr(12'h020, 32'h0000_003F);
        rd_chk("sel rly2 rst", outsel_pkg::OFS_SEL_RLY2, 32'd5);
        rd_chk("unmapped", 12'h020, 32'h0000_0000);
        $display("test reset values done");
        // every code: its own source only, then all but it; codes with no source get every source, then none
        for (int c = 0; c < 64; c++)
        begin
            k = src_of(c);
            s = (k < 0) ? '1 : (k < 100) ? 28'(1) << k : '0;
            v = (k >= 100) ? 4'(4'h1 << (k - 100)) : (k < 0) ? 4'hF : 4'h0;
            wr(outsel_pkg::OFS_SEL_OC, 32'hFFFF_FF00 | 32'(c));
            wr(outsel_pkg::OFS_SEL_FAST, 32'(c));
            wr(outsel_pkg::OFS_SEL_RLY1, 32'(c));
            wr(outsel_pkg::OFS_SEL_RLY2, 32'(c));
            rd_chk("sel width", outsel_pkg::OFS_SEL_OC, 32'(c));
            drive('0, 4'h0);
            repeat (8) @(posedge clock);
            drive(s, v);
            repeat (8) @(posedge clock);
            check("own source", 32'(load_on),
                  (k >= 0) ? 32'h0000_000F : 32'h0000_0000);
            drive((k < 0) ? '0 : ~s, (k < 0) ? 4'h0 : ~v);
            // the index pulse must lapse after its hold
            repeat ((c == 27) ? HOLD + 10 : 8) @(posedge clock);
            check("other sources", 32'(load_on), 32'h0000_0000);
        end
        $display("test code sweep done");
        wr(outsel_pkg::OFS_SEL_OC, 32'd26);
        wr(outsel_pkg::OFS_SEL_FAST, 32'd30);
        wr(outsel_pkg::OFS_SEL_RLY1, 32'd0);
        wr(outsel_pkg::OFS_SEL_RLY2, 32'd26);
        drive(28'h000_0004, 4'h0);
        repeat (8) @(posedge clock);
        check("terms dc bus", 32'(load_on), 32'h0000_0009);
        rd_chk("status word", outsel_pkg::OFS_STATE, 32'h0000_0009);
        check("bus response", 32'({hreadyout, hresp}), 32'h0000_0002);
        drive(28'h000_0040, 4'h0);
        repeat (8) @(posedge clock);
        check("terms position", 32'(load_on), 32'h0000_0002);
        $display("test terminals done");
        end_sim();
    end
endmodule : tb_output_terminal_function_select
